/* core/gtc_timer.sv */
// General-purpose 32-bit timer with capture, prescaler and postscaler behind an AXI4-Lite slave.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// [RULE_01] Free-running restarts from the same extreme value.
// [RULE_02] Periodic mode restarts from the load value.
// [RULE_03] Current count readable anytime without disturbance.
// [RULE_04] Control register write starts the timer.
// [RULE_05] Interrupt at zero down or full-scale up.
// [RULE_06] Any write to clear register clears interrupt.
// [RULE_07] 32-bit counter, up or down, prescaled.
// [RULE_08] Prescaler divides by 1, 16, 256, 32768.
// [RULE_09] Binary or hours-minutes-seconds-hundredths format.
// [RULE_10] Capture count on selected source first assertion.
// [RULE_11] Capture never stops or alters counting.
// [RULE_12] Software enables sources used for capture.
// [RULE_13] Capture select codes map to sources.
// [RULE_14] Postscaler counts 1 to 256 timeouts; the 8-bit count here covers 1 to 255.
// [RULE_15] Software sets bit 18 and postscale count.
// [RULE_16] Postscaler reaching target raises interrupt.
// [RULE_17] Keeps counting in low power on slow sources.
// [RULE_18] Overflow reloads counter from load register.
// [RULE_19] Load, count, capture are 32-bit; two read-only.
// [RULE_20] Program load before control register.
// [RULE_21] Prescaler codes decode to four divisors.
// [RULE_22] Bits 6,7,8: periodic, enable, count up.
// [RULE_23] Postscale zero means one; reads live count.
// [RULE_24] Bit 17 capture enable, bits 16:12 select.
// [RULE_25] Capture on rising source, re-arm after release.
// [RULE_26] Interrupt holds until clear register written.
module gtc_timer
  import gtc_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   nrst,
  input  wire logic [31:0]            s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [31:0]            s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   slow_osc_clk,
  input  wire logic                   div_core_clk,
  input  wire logic                   gpio_clk_pin,
  input  wire logic [GTC_NUM_SRC-1:0] irq_sources,
  output logic                        timer_irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [31:0] load_ff, count_ff, ctrl_ff, capture_ff, rdata_ff;
  logic [31:0] nxt_count;
  logic [7:0]  post_tgt_ff, post_cnt_ff;
  logic [14:0] pre_cnt_ff;
  logic [14:0] pre_tc;
  logic [2:0]  clk_s1_ff, clk_s2_ff, clk_s3_ff;
  logic [GTC_NUM_SRC-1:0] src_s1_ff, src_s2_ff;
  logic        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic        aw_hold_ff, w_hold_ff, bad_w_ff, bad_r_ff, irq_ff, postflag_ff;
  logic        armed_ff, post_match;
  logic [31:0] aw_addr_ff, w_data_ff;
  logic        do_write, src_edge, src_level, tick, term, at_end;
  logic [1:0]  fmt;
  logic        up, periodic, run;
  logic [31:0] start_val, nxt_wdata;

  assign periodic = ctrl_ff[GTC_F_PERIODIC];
  assign run      = ctrl_ff[GTC_F_RUN];
  assign up       = ctrl_ff[GTC_F_UP];
  assign fmt      = ctrl_ff[GTC_F_FORMAT_LO +: 2];

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      aw_addr_ff <= 32'h00000000;
      w_data_ff  <= 32'h00000000;
      bvalid_ff  <= 1'b0;
      bad_w_ff   <= 1'b0;
    end
    else
    begin
      awready_ff <= !aw_hold_ff && !awready_ff && s_axi_awvalid;
      wready_ff  <= !w_hold_ff && !wready_ff && s_axi_wvalid;
      if (awready_ff && s_axi_awvalid)
      begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (wready_ff && s_axi_wvalid)
      begin
        w_hold_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
      end
      if (do_write)
      begin
        aw_hold_ff <= 1'b0;
        w_hold_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bad_w_ff   <= !(aw_addr_ff == GTC_ADDR_LOAD || aw_addr_ff == GTC_ADDR_CONTROL
                        || aw_addr_ff == GTC_ADDR_CLEAR);
      end
      else if (bvalid_ff && s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h00000000;
      bad_r_ff   <= 1'b0;
    end
    else
    begin
      arready_ff <= !arready_ff && !rvalid_ff && s_axi_arvalid;
      if (arready_ff && s_axi_arvalid)
      begin
        rvalid_ff <= 1'b1;
        bad_r_ff  <= 1'b0;
        unique case (s_axi_araddr)
          GTC_ADDR_LOAD:    rdata_ff <= load_ff;
          GTC_ADDR_COUNT:   rdata_ff <= count_ff;  // see [RULE_03]
          GTC_ADDR_CONTROL: rdata_ff <= {post_cnt_ff, ctrl_ff[23:20], postflag_ff,
                                         ctrl_ff[18:0]};  // see [RULE_23]
          GTC_ADDR_CAPTURE: rdata_ff <= capture_ff;  // see [RULE_19]
          default:
          begin
            rdata_ff <= 32'h00000000;
            bad_r_ff <= 1'b1;
          end
        endcase
      end
      else if (rvalid_ff && s_axi_rready)
        rvalid_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // Control and load registers
  // ****************************************************************
  always_comb
  begin
    nxt_wdata = w_data_ff & GTC_CTRL_WMASK;
    if (w_data_ff[GTC_F_POSTVAL_LO +: 8] == 8'h00)
      nxt_wdata[GTC_F_POSTVAL_LO +: 8] = 8'h01;  // see [RULE_23]
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      ctrl_ff     <= GTC_RST_CONTROL;
      load_ff     <= GTC_RST_LOAD;
      post_tgt_ff <= GTC_RST_CONTROL[GTC_F_POSTVAL_LO +: 8];
    end
    else if (do_write && aw_addr_ff == GTC_ADDR_CONTROL)
    begin
      ctrl_ff     <= nxt_wdata;  // see [RULE_04] [RULE_22] [RULE_24]
      post_tgt_ff <= nxt_wdata[GTC_F_POSTVAL_LO +: 8];  // see [RULE_15]
    end
    else if (do_write && aw_addr_ff == GTC_ADDR_LOAD)
      load_ff <= w_data_ff;  // see [RULE_19] [RULE_20]
  end

  // ****************************************************************
  // Clock source synchronisers and prescaler
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      clk_s1_ff <= 3'h0;
      clk_s2_ff <= 3'h0;
      clk_s3_ff <= 3'h0;
    end
    else
    begin
      clk_s1_ff <= {gpio_clk_pin, div_core_clk, slow_osc_clk};
      clk_s2_ff <= clk_s1_ff;
      clk_s3_ff <= clk_s2_ff;
    end
  end

  // Rising edges of the selected synchronised source, or every cycle for the core clock; slow and pin sources run in low power.
  always_comb
  begin
    unique case (ctrl_ff[GTC_F_CLKSEL_LO +: 2])
      GTC_CLK_SLOW: src_edge = clk_s2_ff[0] && !clk_s3_ff[0];  // see [RULE_17]
      GTC_CLK_DIV:  src_edge = clk_s2_ff[1] && !clk_s3_ff[1];
      GTC_CLK_CORE: src_edge = 1'b1;
      GTC_CLK_PIN:  src_edge = clk_s2_ff[2] && !clk_s3_ff[2];  // see [RULE_17]
    endcase
    unique case (ctrl_ff[GTC_F_SCALE_LO +: 4])
      GTC_SCALE_16:  pre_tc = GTC_DIV_16_TC;  // see [RULE_08] [RULE_21]
      GTC_SCALE_256: pre_tc = GTC_DIV_256_TC;
      GTC_SCALE_32K: pre_tc = GTC_DIV_32K_TC;
      default:       pre_tc = 15'h0000;
    endcase
  end

  assign tick = run && src_edge && (pre_cnt_ff >= pre_tc);

  always_ff @(posedge core_clk)
  begin
    if (!nrst || !run)
      pre_cnt_ff <= 15'h0000;
    else if (src_edge)
      pre_cnt_ff <= (pre_cnt_ff >= pre_tc) ? 15'h0000 : pre_cnt_ff + 15'h0001;  // see [RULE_08]
  end

  // ****************************************************************
  // Main counter
  // ****************************************************************
  // Terminal value per format: full scale is all ones or the packed time maximum.
  always_comb
  begin
    start_val = periodic ? load_ff : (up ? 32'h00000000 : term_val(fmt));  // see [RULE_01] [RULE_02]
    at_end    = up ? (count_ff == term_val(fmt)) : (count_ff == 32'h00000000);
    term      = tick && at_end;  // see [RULE_05]
    nxt_count = count_ff;
    if (term)
      nxt_count = start_val;  // see [RULE_18]
    else if (fmt == GTC_FMT_BIN)
      nxt_count = up ? count_ff + 32'h00000001 : count_ff - 32'h00000001;  // see [RULE_07]
    else
      nxt_count = hms_step(count_ff, up, fmt);  // see [RULE_09]
  end

  function automatic logic [31:0] term_val(input logic [1:0] f);
    logic [7:0] hr;
    hr = (f == GTC_FMT_HMS23) ? GTC_HOUR23_MAX : GTC_HOUR255_MAX;
    term_val = (f == GTC_FMT_BIN) ? 32'hFFFFFFFF : {hr, GTC_MIN_MAX, GTC_SEC_MAX, GTC_HUND_MAX};
  endfunction : term_val

  // Steps a packed hours:minutes:seconds:hundredths value by one hundredth.
  function automatic logic [31:0] hms_step(input logic [31:0] v, input logic u, input logic [1:0] f);
    logic [7:0] mx [4];
    logic [31:0] r;
    logic        c;
    mx[0] = GTC_HUND_MAX;
    mx[1] = GTC_SEC_MAX;
    mx[2] = GTC_MIN_MAX;
    mx[3] = (f == GTC_FMT_HMS23) ? GTC_HOUR23_MAX : GTC_HOUR255_MAX;
    r = v;
    c = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      if (c)
      begin
        if (u)
        begin
          c = (v[i*8 +: 8] >= mx[i]);
          r[i*8 +: 8] = c ? 8'h00 : v[i*8 +: 8] + 8'h01;
        end
        else
        begin
          c = (v[i*8 +: 8] == 8'h00);
          r[i*8 +: 8] = c ? mx[i] : v[i*8 +: 8] - 8'h01;
        end
      end
    end
    hms_step = r;
  endfunction : hms_step

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      count_ff <= GTC_RST_COUNT;
    else if (do_write && aw_addr_ff == GTC_ADDR_CONTROL)
      count_ff <= nxt_wdata[GTC_F_PERIODIC] ? load_ff : count_ff;  // see [RULE_04] [RULE_02]
    else if (tick)
      count_ff <= nxt_count;  // see [RULE_01] [RULE_07]
  end

  // ****************************************************************
  // Postscaler and interrupt
  // ****************************************************************
  // The postscaler counts down from its target, so after reset it reads back as the target.
  assign post_match = (post_cnt_ff <= 8'h01);  // see [RULE_14]

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      post_cnt_ff <= GTC_RST_CONTROL[GTC_F_POSTVAL_LO +: 8];
      postflag_ff <= 1'b0;
    end
    else if (do_write && aw_addr_ff == GTC_ADDR_CONTROL)
    begin
      post_cnt_ff <= nxt_wdata[GTC_F_POSTVAL_LO +: 8];  // see [RULE_23]
      postflag_ff <= term && ctrl_ff[GTC_F_POSTEN] && post_match;
    end
    else if (term && ctrl_ff[GTC_F_POSTEN])
    begin
      post_cnt_ff <= post_match ? post_tgt_ff : post_cnt_ff - 8'h01;  // see [RULE_14]
      postflag_ff <= post_match;
    end
  end

  // Set wins over a clear written in the same cycle.
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      irq_ff <= 1'b0;
    else if (term && (!ctrl_ff[GTC_F_POSTSRC] || (ctrl_ff[GTC_F_POSTEN] && post_match)))
      irq_ff <= 1'b1;  // see [RULE_05] [RULE_16] [RULE_26]
    else if (do_write && aw_addr_ff == GTC_ADDR_CLEAR)
      irq_ff <= 1'b0;  // see [RULE_06]
  end

  // ****************************************************************
  // Event capture
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < GTC_NUM_SRC; gi++)
    begin : g_src_sync
      always_ff @(posedge core_clk)
      begin
        if (!nrst)
        begin
          src_s1_ff[gi] <= 1'b0;
          src_s2_ff[gi] <= 1'b0;
        end
        else
        begin
          src_s1_ff[gi] <= irq_sources[gi];  // see [RULE_12]
          src_s2_ff[gi] <= src_s1_ff[gi];
        end
      end
    end
  endgenerate

  // Reserved codes 0, 5, 6, 7 select nothing.
  always_comb
  begin
    unique case (ctrl_ff[GTC_F_CAPSEL_LO +: 5])
      5'h00, 5'h05, 5'h06, 5'h07: src_level = 1'b0;  // see [RULE_13]
      default: src_level = (ctrl_ff[GTC_F_CAPSEL_LO +: 5] < 5'(GTC_NUM_SRC))
                           ? src_s2_ff[ctrl_ff[GTC_F_CAPSEL_LO +: 5]] : 1'b0;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      armed_ff   <= 1'b1;
      capture_ff <= GTC_RST_CAPTURE;
    end
    else
    begin
      armed_ff <= !src_level;  // see [RULE_25]
      if (ctrl_ff[GTC_F_CAPEN] && src_level && armed_ff)
        capture_ff <= count_ff;  // see [RULE_10] [RULE_11] [RULE_24]
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bad_w_ff ? GTC_RESP_SLVERR : GTC_RESP_OKAY;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = bad_r_ff ? GTC_RESP_SLVERR : GTC_RESP_OKAY;
  assign timer_irq     = irq_ff;

endmodule : gtc_timer
`default_nettype wire

/* core/gtc_pkg.sv */
// Package of register offsets, field positions, reset values and constants for the general timer.
package gtc_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [31:0] GTC_ADDR_LOAD    = 32'hFFFF0320;
  localparam logic [31:0] GTC_ADDR_COUNT   = 32'hFFFF0324;
  localparam logic [31:0] GTC_ADDR_CONTROL = 32'hFFFF0328;
  localparam logic [31:0] GTC_ADDR_CLEAR   = 32'hFFFF032C;
  localparam logic [31:0] GTC_ADDR_CAPTURE = 32'hFFFF0330;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] GTC_RST_LOAD     = 32'h00000000;
  localparam logic [31:0] GTC_RST_COUNT    = 32'hFFFFFFFF;
  localparam logic [31:0] GTC_RST_CONTROL  = 32'h01000000;
  localparam logic [31:0] GTC_RST_CAPTURE  = 32'h00000000;

  // ****************************************************************
  // Control field positions
  // ****************************************************************
  localparam int GTC_F_SCALE_LO   = 0;
  localparam int GTC_F_FORMAT_LO  = 4;
  localparam int GTC_F_PERIODIC   = 6;
  localparam int GTC_F_RUN        = 7;
  localparam int GTC_F_UP         = 8;
  localparam int GTC_F_CLKSEL_LO  = 9;
  localparam int GTC_F_CAPSEL_LO  = 12;
  localparam int GTC_F_CAPEN      = 17;
  localparam int GTC_F_POSTSRC    = 18;
  localparam int GTC_F_POSTFLAG   = 19;
  localparam int GTC_F_POSTEN     = 23;
  localparam int GTC_F_POSTVAL_LO = 24;

  // Writable control bits; reserved and read-only bits stay zero.
  localparam logic [31:0] GTC_CTRL_WMASK  = 32'hFF87F7FF;

  // ****************************************************************
  // Prescaler codes and divide terminal counts
  // ****************************************************************
  localparam logic [3:0]  GTC_SCALE_1     = 4'h0;
  localparam logic [3:0]  GTC_SCALE_16    = 4'h4;
  localparam logic [3:0]  GTC_SCALE_256   = 4'h8;
  localparam logic [3:0]  GTC_SCALE_32K   = 4'hF;
  localparam logic [14:0] GTC_DIV_16_TC   = 15'h000F;
  localparam logic [14:0] GTC_DIV_256_TC  = 15'h00FF;
  localparam logic [14:0] GTC_DIV_32K_TC  = 15'h7FFF;

  // ****************************************************************
  // Clock source codes and count format codes
  // ****************************************************************
  localparam logic [1:0]  GTC_CLK_SLOW    = 2'h0;
  localparam logic [1:0]  GTC_CLK_DIV     = 2'h1;
  localparam logic [1:0]  GTC_CLK_CORE    = 2'h2;
  localparam logic [1:0]  GTC_CLK_PIN     = 2'h3;
  localparam logic [1:0]  GTC_FMT_BIN     = 2'h0;
  localparam logic [1:0]  GTC_FMT_HMS255  = 2'h3;
  localparam logic [1:0]  GTC_FMT_HMS23   = 2'h2;

  // Time format field maxima: hundredths, seconds, minutes, and hours for both hour ranges.
  localparam logic [7:0]  GTC_HUND_MAX    = 8'h63;
  localparam logic [7:0]  GTC_SEC_MAX     = 8'h3B;
  localparam logic [7:0]  GTC_MIN_MAX     = 8'h3B;
  localparam logic [7:0]  GTC_HOUR23_MAX  = 8'h17;
  localparam logic [7:0]  GTC_HOUR255_MAX = 8'hFF;

  // Capture source count and AXI responses.
  localparam int          GTC_NUM_SRC     = 18;
  localparam logic [1:0]  GTC_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  GTC_RESP_SLVERR = 2'h2;

endpackage : gtc_pkg

/* tb/gtc_timer_sva.sv */
// Checker of bus answers and interrupt holding at the timer ports.
`timescale 1ns/10ps
`default_nettype none
module gtc_timer_sva
  import gtc_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        timer_irq
);
  logic [31:0] wa_ff;
  logic [31:0] ra_ff;
  logic        clr_ff;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Remembers the addresses taken and a pending write to the clear register.
  always_ff @(posedge core_clk)
  begin
    if (s_axi_awvalid && s_axi_awready)
      wa_ff <= s_axi_awaddr;
    if (s_axi_arvalid && s_axi_arready)
      ra_ff <= s_axi_araddr;
    if (!nrst)
      clr_ff <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready)
      clr_ff <= (s_axi_awaddr == GTC_ADDR_CLEAR);
    else if (s_axi_bvalid && s_axi_bready)
      clr_ff <= 1'b0;
  end
  AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready held too long");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_RO_WR: assert property (s_axi_bvalid && (wa_ff == GTC_ADDR_COUNT || wa_ff == GTC_ADDR_CAPTURE)
    |-> s_axi_bresp == GTC_RESP_SLVERR)
    else $error("read-only write not refused");
  AST_LOAD_WR: assert property (s_axi_bvalid && wa_ff == GTC_ADDR_LOAD
    |-> s_axi_bresp == GTC_RESP_OKAY)
    else $error("load write refused");
  AST_CLR_RD: assert property (s_axi_rvalid && ra_ff == GTC_ADDR_CLEAR
    |-> s_axi_rresp == GTC_RESP_SLVERR && s_axi_rdata == 32'h00000000)
    else $error("clear register readable");
  AST_CLR_WR: assert property (s_axi_bvalid && clr_ff |-> s_axi_bresp == GTC_RESP_OKAY)
    else $error("clear write refused");
  AST_IRQ_FALL: assert property ($fell(timer_irq) |-> clr_ff)
    else $error("interrupt dropped without clear");
endmodule : gtc_timer_sva
`default_nettype wire

/* tb/gtc_timer_tb.sv */
// Self-checking bench for the general timer.
`timescale 1ns/10ps
`default_nettype none
module gtc_timer_tb
  import gtc_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, timer_irq;
  logic        slow_osc_clk = 1'b0, div_core_clk = 1'b0, gpio_clk_pin;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d, c1, c2, cap, prv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [17:0] irq_sources;
  int          n_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          t0, n, code;
  int          divs[$] = '{1, 16, 256, 32768, 1};
  logic [3:0]  scl[$] = '{4'h0, 4'h4, 4'h8, 4'hF, 4'h2};
  gtc_timer i_gtc_timer (.*);
  always #5 core_clk = ~core_clk;
  // ****************************************************************
  // Bus tasks and comparisons
  // ****************************************************************
  task automatic wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= v;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic rng(input logic [31:0] x, input logic [31:0] lo, input logic [31:0] hi);
    chk({31'h0, x >= lo && x <= hi}, 32'h1);
  endtask : rng
  task automatic wait_irq(output int k);
    k = 0;
    while (timer_irq !== 1'b1 && k < 2000)
    begin
      @(posedge core_clk);
      k++;
    end
  endtask : wait_irq
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  // Counts cycles, moves the slow sources and cuts a hang short.
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    div_core_clk <= 1'($urandom);
    if (cyc % 7 == 0)
      slow_osc_clk <= ~slow_osc_clk;
    if (cyc > 20000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    gpio_clk_pin = 1'b0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, irq_sources} = '0;
    s_axi_wstrb = 4'hF;
    d = $urandom(84999);
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    rd(GTC_ADDR_LOAD, d, r); chk(d, GTC_RST_LOAD);
    rd(GTC_ADDR_COUNT, d, r); chk(d, GTC_RST_COUNT);
    rd(GTC_ADDR_CONTROL, d, r); chk(d, GTC_RST_CONTROL);
    rd(GTC_ADDR_CLEAR, d, r); chk({30'h0, r}, {30'h0, GTC_RESP_SLVERR});
    rd(32'hFFFF0334, d, r); chk({30'h0, r}, {30'h0, GTC_RESP_SLVERR});
    wr(GTC_ADDR_COUNT, $urandom, r); chk({30'h0, r}, {30'h0, GTC_RESP_SLVERR});
    wr(GTC_ADDR_CAPTURE, $urandom, r); chk({30'h0, r}, {30'h0, GTC_RESP_SLVERR});
    rd(GTC_ADDR_COUNT, d, r); chk(d, GTC_RST_COUNT);
    c1 = $urandom;
    wr(GTC_ADDR_LOAD, c1, r);
    rd(GTC_ADDR_LOAD, d, r); chk(d, c1);
    $display("test registers done");
    wr(GTC_ADDR_LOAD, 32'd40, r);
    wr(GTC_ADDR_CONTROL, 32'h000004C0, r);
    t0 = cyc;
    rd(GTC_ADDR_CONTROL, d, r); chk(d & 32'h00F7FFFF, 32'h000004C0);
    rd(GTC_ADDR_COUNT, d, r); rng(d, 32'd25, 32'd40);
    wait_irq(n); rng(32'(cyc - t0), 32'd30, 32'd46);
    repeat (100) @(posedge core_clk);
    chk({31'h0, timer_irq}, 32'h1);
    wr(GTC_ADDR_CLEAR, $urandom, r);
    chk({31'h0, timer_irq}, 32'h0);
    wait_irq(n); rng(32'(n), 32'd8, 32'd28);
    rd(GTC_ADDR_COUNT, d, r); rng(d, 32'd0, 32'd40);
    $display("test periodic done");
    wr(GTC_ADDR_CONTROL, 32'h00000480, r);
    repeat (60) @(posedge core_clk);
    rd(GTC_ADDR_COUNT, d, r); rng(d, 32'hFFFFFF00, 32'hFFFFFFFF);
    wr(GTC_ADDR_CONTROL, 32'h00000580, r);
    wr(GTC_ADDR_CLEAR, 32'h0, r);
    wait_irq(n); rng(32'(n), 32'd1, 32'd300);
    rd(GTC_ADDR_COUNT, d, r); rng(d, 32'd0, 32'd40);
    $display("test free running done");
    foreach (divs[i])
    begin
      wr(GTC_ADDR_CONTROL, 32'h00000480 | 32'(scl[i]), r);
      rd(GTC_ADDR_COUNT, c1, r);
      repeat (512) @(posedge core_clk);
      rd(GTC_ADDR_COUNT, c2, r);
      rng(c1 - c2, 32'(512 / divs[i]), 32'(520 / divs[i] + 1));
    end
    $display("test prescaler done");
    wr(GTC_ADDR_CONTROL, 32'h00000680, r);
    rd(GTC_ADDR_COUNT, c1, r);
    repeat (12)
    begin
      gpio_clk_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      gpio_clk_pin <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    repeat (8) @(posedge core_clk);
    rd(GTC_ADDR_COUNT, c2, r); chk(c1 - c2, 32'd12);
    $display("test pin clock done");
    prv = GTC_RST_CAPTURE;
    for (int c = 0; c < 19; c++)
    begin
      code = (c < 18) ? c : 9;
      wr(GTC_ADDR_CONTROL, 32'h00000480 | ((c < 18) ? 32'h00020000 : 32'h0) | 32'(code << 12), r);
      rd(GTC_ADDR_COUNT, c1, r);
      irq_sources <= 18'($urandom) | (18'h1 << code);
      repeat (6) @(posedge core_clk);
      rd(GTC_ADDR_CAPTURE, cap, r);
      rd(GTC_ADDR_COUNT, c2, r);
      if (c == 0 || (c > 4 && c < 8) || c == 18)
        chk(cap, prv);
      else
        rng(cap, c2, c1);
      repeat (4) @(posedge core_clk);
      rd(GTC_ADDR_CAPTURE, d, r); chk(d, cap);
      prv = cap;
      irq_sources <= '0;
      repeat (4) @(posedge core_clk);
    end
    $display("test capture done");
    wr(GTC_ADDR_LOAD, 32'h00000100, r);
    wr(GTC_ADDR_CONTROL, 32'h000004E0, r);
    rd(GTC_ADDR_COUNT, d, r); rng(d, 32'h00000050, 32'h00000063);
    $display("test time format done");
    wr(GTC_ADDR_LOAD, 32'd20, r);
    for (int p = 0; p < 2; p++)
    begin
      n = (p == 0) ? 3 : 0;
      wr(GTC_ADDR_CONTROL, 32'h008404C0 | 32'(n << 24), r);
      t0 = cyc;
      wr(GTC_ADDR_CLEAR, 32'h0, r);
      wait_irq(code);
      n = (n == 0) ? 21 : 21 * n;
      rng(32'(cyc - t0), 32'(n - 6), 32'(n + 3));
    end
    $display("test postscaler done");
    tally_and_finish();
  end
endmodule : gtc_timer_tb
bind gtc_timer gtc_timer_sva i_gtc_timer_sva (.*);
`default_nettype wire
